/* fault_src_model.sv */
/*
  Far-side model: fault comparators, the fault pin and the bridge pins.
  Assumes the bench commands each fault source through one trip bit.
*/
module fault_src_model (
  // Commands from the bench.
  input wire logic [2:0] trip,
  // Bridge pins from the block.
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  // Fault sources toward the block.
  output logic cmp1_out,
  output logic cmp2_out,
  output logic fault_pin_n,
  // Levels seen by the switch drivers.
  output logic [3:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign cmp1_out = trip[0];
  assign cmp2_out = trip[1];
  assign fault_pin_n = ~trip[2];
  // Released pins fall to pull-downs, so the switches stay off.
  assign pin_level = pin_out & ~pin_oe_n;
endmodule : fault_src_model

/* pwm_auto_shutdown_restart.sv */
/*
  Auto-shutdown and auto-restart control of an enhanced PWM unit, with
  output polarity, shutdown drive states and the duty and dead-band
  registers that feed the modulator.
  Assumes the modulator, period timer and comparators sit outside on clk;
  comparator outputs and the fault pin are asynchronous to clk.
*/
// Contract
// - Bit 7 of shutdown config shows shutdown occurred, outputs held.
// - Three-bit source field picks none, comparators, fault pin or mixes.
// - Pair A/C shutdown drive: 00 low, 01 high, 1x tri-state.
// - Pair B/D shutdown drive: 00 low, 01 high, 1x tri-state.
// - Auto-restart on: flag stays while cause lasts, then clears itself.
// - Auto-restart off: flag stays until software clears it.
// - After flag clears, outputs stay shut until next period boundary.
// - Writes to the flag are ignored while a selected cause is active.
// - Comparator sources are levels; flag cannot clear while they persist.
// - Software writing one to the flag forces shutdown.
// - Mode bits 1:0 set each pair's output polarity independently.
// - Enable module, wait one period flag, then enable output pins.
// - Duty value is duty low byte plus control bits 5:4.
// - Reset returns every register to zero, plain PWM behaviour; zero mode bits 3:2 leave the pins released instead.
// - A shutdown event forces outputs without waiting for any clock.
// - Flag set at period start holds outputs shut for that period.
// - Low level on the fault pin is a shutdown event when selected.
module pwm_auto_shutdown_restart
  import pwm_shutdown_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Shutdown sources, asynchronous.
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic fault_pin_n,
  // Modulator side, on clk.
  input wire logic period_start,
  input wire logic [3:0] pwm_raw,
  output logic [9:0] duty_value,
  output logic [6:0] deadband_count,
  output logic [1:0] output_config_sel,
  // Bridge pins.
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic pwm_oe_n_a,
  output logic pwm_oe_n_b,
  output logic pwm_oe_n_c,
  output logic pwm_oe_n_d
);

  // True when the selected sources report a fault.
  function automatic logic src_hit(input logic [2:0] sel, input logic c1,
                                   input logic c2, input logic flt_n);
    logic hit;
    hit = 1'b0;
    case (sel)
      src_none: hit = 1'b0;
      src_cmp1: hit = c1;
      src_cmp2: hit = c2;
      src_cmp_any: hit = c1 | c2;
      src_fault: hit = ~flt_n;
      src_fault_cmp1: hit = ~flt_n | c1;
      src_fault_cmp2: hit = ~flt_n | c2;
      src_all: hit = ~flt_n | c1 | c2;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : src_hit

  logic rst_meta;
  logic rst_sync_n;
  logic [2:0] src_meta;
  logic [2:0] src_sync;
  logic [7:0] shutdown_config;
  logic [7:0] pwm_control;
  logic [7:0] deadband_restart;
  logic [7:0] duty_low;
  logic [7:0] duty_high;
  logic period_timer_flag;
  logic [7:0] next_shutdown_config;
  logic [7:0] next_pwm_control;
  logic [7:0] next_deadband_restart;
  logic [7:0] next_duty_low;
  logic [7:0] next_duty_high;
  logic next_period_timer_flag;
  logic [7:0] next_reg_rdata;
  hold_e hold;
  hold_e next_hold;
  logic cause;
  logic async_trip;
  logic shut;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic shutdown_event_flag;
  logic [2:0] shutdown_source_sel;
  logic [1:0] pair_ac_shutdown_state;
  logic [1:0] pair_bd_shutdown_state;
  logic auto_restart_en;
  logic [1:0] pair_polarity_sel;
  logic pwm_mode;
  logic wr_config;

  // Reset release passes two flops so every register leaves reset together.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // source synchroniser
  // Only the second stage feeds logic; the fault pin idles high.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      src_meta <= sync_reset;
      src_sync <= sync_reset;
    end
    else
    begin
      src_meta <= {fault_pin_n, cmp2_out, cmp1_out};
      src_sync <= src_meta;
    end
  end

  // Field views of the configuration registers.
  assign shutdown_event_flag = shutdown_config[flag_bit];
  assign shutdown_source_sel = shutdown_config[src_hi:src_lo];
  assign pair_ac_shutdown_state = shutdown_config[ac_hi:ac_lo];
  assign pair_bd_shutdown_state = shutdown_config[bd_hi:bd_lo];
  assign auto_restart_en = deadband_restart[restart_bit];
  assign pair_polarity_sel = pwm_control[mode_lo + 1:mode_lo];
  assign pwm_mode = (pwm_control[mode_hi:mode_hi - 1] == mode_pwm);
  assign wr_config = reg_wr && (reg_addr == reg_shutdown_config);

  // fault pin low
  // The flag uses synchronised sources; the pins use the raw ones.
  assign cause = src_hit(shutdown_source_sel, src_sync[0], src_sync[1], src_sync[2]);
  assign async_trip = src_hit(shutdown_source_sel, cmp1_out, cmp2_out, fault_pin_n);

  // Next register values, read data and flag behaviour.
  always_comb
  begin
    next_shutdown_config = shutdown_config;
    next_pwm_control = pwm_control;
    next_deadband_restart = deadband_restart;
    next_duty_low = duty_low;
    next_duty_high = duty_high;
    next_period_timer_flag = period_timer_flag;
    next_reg_rdata = reg_rdata;
    if (reg_wr)
    begin
      case (reg_addr)
        reg_shutdown_config: next_shutdown_config = reg_wdata;
        reg_pwm_control: next_pwm_control = reg_wdata;
        reg_deadband_restart: next_deadband_restart = reg_wdata;
        reg_duty_low: next_duty_low = reg_wdata;
        reg_duty_high: next_duty_high = reg_wdata;
        reg_period_status: next_period_timer_flag = reg_wdata[period_flag_bit];
        default: next_duty_high = duty_high;
      endcase
    end
    // forced shutdown
    // A written one lands through the plain store above.
    // auto restart
    // Without a write, auto-restart drops the flag once the cause is gone.
    if (!wr_config && auto_restart_en && !cause)
    begin
      next_shutdown_config[flag_bit] = 1'b0;
    end
    // sticky flag
    // An active cause sets the flag and beats any software clear.
    if (cause)
    begin
      next_shutdown_config[flag_bit] = 1'b1;
    end
    // period flag set
    // The boundary wins over a software clear in the same cycle.
    if (period_start)
    begin
      next_period_timer_flag = 1'b1;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        reg_shutdown_config: next_reg_rdata = shutdown_config;
        reg_pwm_control: next_reg_rdata = pwm_control;
        reg_deadband_restart: next_reg_rdata = deadband_restart;
        reg_duty_low: next_reg_rdata = duty_low;
        reg_duty_high: next_reg_rdata = duty_high;
        reg_period_status: next_reg_rdata = {7'h00, period_timer_flag};
        default: next_reg_rdata = reg_reset;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      shutdown_config <= reg_reset;
      pwm_control <= reg_reset;
      deadband_restart <= reg_reset;
      duty_low <= reg_reset;
      duty_high <= reg_reset;
      period_timer_flag <= 1'b0;
      reg_rdata <= reg_reset;
    end
    else
    begin
      shutdown_config <= next_shutdown_config;
      pwm_control <= next_pwm_control;
      deadband_restart <= next_deadband_restart;
      duty_low <= next_duty_low;
      duty_high <= next_duty_high;
      period_timer_flag <= next_period_timer_flag;
      reg_rdata <= next_reg_rdata;
    end
  end

  // whole period held
  // Release happens only on a boundary seen after the flag has gone.
  always_comb
  begin
    next_hold = hold;
    case (hold)
      st_run:
        if (shutdown_event_flag || cause)
          next_hold = st_shut;
      st_shut:
        if (!shutdown_event_flag && !cause)
          next_hold = st_wait;
      st_wait:
        if (shutdown_event_flag || cause)
          next_hold = st_shut;
        else if (period_start)
          next_hold = st_run;
      default: next_hold = st_shut;
    endcase
  end

  // Hold state register.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      hold <= st_run;
    else
      hold <= next_hold;
  end

  // asynchronous force
  // The raw trip bypasses the clock so a fault acts within gate delay.
  assign shut = (hold != st_run) || shutdown_event_flag || async_trip;

  // outputs held
  // Pins A and C share pair 0, pins B and D pair 1.
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    localparam int pair = i % 2;
    logic [1:0] sd_state;
    logic inv;
    assign sd_state = (pair == 0) ? pair_ac_shutdown_state : pair_bd_shutdown_state;
    assign inv = (pair == 0) ? pair_polarity_sel[1] : pair_polarity_sel[0];
    // pair A/C and B/D drive
    // Bit 1 of the drive code releases the pin; bit 0 picks the level.
    assign pin_out[i] = shut ? sd_state[0] : (pwm_raw[i] ^ inv);
    assign pin_oe_n[i] = shut ? sd_state[1] : ~pwm_mode;
  end

  assign pwm_out_a = pin_out[0];
  assign pwm_out_b = pin_out[1];
  assign pwm_out_c = pin_out[2];
  assign pwm_out_d = pin_out[3];
  assign pwm_oe_n_a = pin_oe_n[0];
  assign pwm_oe_n_b = pin_oe_n[1];
  assign pwm_oe_n_c = pin_oe_n[2];
  assign pwm_oe_n_d = pin_oe_n[3];

  assign duty_value = {duty_low, pwm_control[lsb_hi:lsb_lo]};
  assign deadband_count = deadband_restart[dead_hi:0];
  assign output_config_sel = pwm_control[cfg_hi:cfg_lo];

  // Checks on flag, hold and pin behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_cause_gone;
    !cause && !wr_config;
  endsequence

  sequence s_cleared;
    $fell(shutdown_event_flag) ##1 !cause && !shutdown_event_flag;
  endsequence

  property p_cause_sets_flag;
    cause |=> shutdown_event_flag;
  endproperty
  a_cause_sets_flag: assert property (p_cause_sets_flag)
    else $error("Flag not set by an active cause.");

  property p_write_ignored;
    cause && wr_config && !reg_wdata[flag_bit] |=> shutdown_event_flag;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("Flag cleared while cause active.");

  property p_auto_clear;
    auto_restart_en && shutdown_event_flag ##0 s_cause_gone |=> !shutdown_event_flag;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("Auto-restart did not clear flag.");

  property p_sticky;
    !auto_restart_en && shutdown_event_flag && !wr_config |=> shutdown_event_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Flag cleared without software.");

  property p_force;
    wr_config && reg_wdata[flag_bit] |=> shutdown_event_flag ##0 shut;
  endproperty
  a_force: assert property (p_force)
    else $error("Forced shutdown not taken.");

  property p_wait_boundary;
    s_cleared ##0 !period_start |=> shut;
  endproperty
  a_wait_boundary: assert property (p_wait_boundary)
    else $error("Outputs resumed before period boundary.");

  property p_release;
    hold == st_wait && !cause && !shutdown_event_flag && period_start |=> hold == st_run;
  endproperty
  a_release: assert property (p_release)
    else $error("Boundary did not release outputs.");

  property p_period_flag;
    period_start |=> period_timer_flag;
  endproperty
  a_period_flag: assert property (p_period_flag)
    else $error("Period flag not set at boundary.");

  // The raw trip must reach the pin enables, not only the internal shut term.
  property p_async;
    async_trip |-> shut && pwm_oe_n_a == pair_ac_shutdown_state[1] &&
      pwm_oe_n_b == pair_bd_shutdown_state[1];
  endproperty
  a_async: assert property (p_async)
    else $error("Raw fault did not force outputs.");

  property p_tristate_ac;
    shut && pair_ac_shutdown_state[1] |-> pwm_oe_n_a && pwm_oe_n_c;
  endproperty
  a_tristate_ac: assert property (p_tristate_ac)
    else $error("Pair A/C not released in tri-state.");

  property p_drive_bd;
    shut && !pair_bd_shutdown_state[1] |->
      !pwm_oe_n_b && pwm_out_d == pair_bd_shutdown_state[0];
  endproperty
  a_drive_bd: assert property (p_drive_bd)
    else $error("Pair B/D shutdown level wrong.");

endmodule : pwm_auto_shutdown_restart

/* pwm_shutdown_pkg.sv */
/*
  Constants for the PWM auto-shutdown and auto-restart control block:
  register indices, field positions, reset values, source codes, states.
  Assumes an 8-bit register port addressed by index, one register per index.
*/
package pwm_shutdown_pkg;

  // Register indices on the plain register port.
  localparam logic [2:0] reg_shutdown_config = 3'h0;
  localparam logic [2:0] reg_pwm_control = 3'h1;
  localparam logic [2:0] reg_deadband_restart = 3'h2;
  localparam logic [2:0] reg_duty_low = 3'h3;
  localparam logic [2:0] reg_duty_high = 3'h4;
  localparam logic [2:0] reg_period_status = 3'h5;

  // Shutdown configuration fields.
  localparam int flag_bit = 7;
  localparam int src_hi = 6;
  localparam int src_lo = 4;
  localparam int ac_hi = 3;
  localparam int ac_lo = 2;
  localparam int bd_hi = 1;
  localparam int bd_lo = 0;

  // Control register fields.
  localparam int cfg_hi = 7;
  localparam int cfg_lo = 6;
  localparam int lsb_hi = 5;
  localparam int lsb_lo = 4;
  localparam int mode_hi = 3;
  localparam int mode_lo = 0;
  localparam logic [1:0] mode_pwm = 2'h3;

  // Dead-band and restart register fields.
  localparam int restart_bit = 7;
  localparam int dead_hi = 6;

  // Period status register field.
  localparam int period_flag_bit = 0;

  // Reset values.
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [2:0] sync_reset = 3'h4;

  // Shutdown source select codes.
  localparam logic [2:0] src_none = 3'h0;
  localparam logic [2:0] src_cmp1 = 3'h1;
  localparam logic [2:0] src_cmp2 = 3'h2;
  localparam logic [2:0] src_cmp_any = 3'h3;
  localparam logic [2:0] src_fault = 3'h4;
  localparam logic [2:0] src_fault_cmp1 = 3'h5;
  localparam logic [2:0] src_fault_cmp2 = 3'h6;
  localparam logic [2:0] src_all = 3'h7;

  // Shutdown drive codes for a pin pair.
  localparam logic [1:0] drive_low = 2'h0;
  localparam logic [1:0] drive_high = 2'h1;

  // Output hold state.
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_shut = 2'b01,
    st_wait = 2'b10
  } hold_e;

endpackage : pwm_shutdown_pkg

/* tb.sv */
/*
  Self-checking bench for the auto-shutdown block.
  Assumes the block and the far-side model are compiled with it.
*/
module tb
  import pwm_shutdown_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] trip = 3'h0;
  logic cmp1_out, cmp2_out, fault_pin_n;
  logic period_start = 1'b0;
  logic [3:0] pwm_raw = 4'h0;
  logic [9:0] duty_value;
  logic [6:0] deadband_count;
  logic [1:0] output_config_sel;
  logic [3:0] pout, poe_n, pin_level;
  logic [7:0] exp_q[$];
  logic [7:0] ctl = 8'h00;
  logic rd_pend = 1'b0;
  int n_fail = 0;
  int tests_run = 0;

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  pwm_auto_shutdown_restart u_pwm_auto_shutdown_restart (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .fault_pin_n(fault_pin_n),
    .period_start(period_start), .pwm_raw(pwm_raw), .duty_value(duty_value),
    .deadband_count(deadband_count), .output_config_sel(output_config_sel),
    .pwm_out_a(pout[0]), .pwm_out_b(pout[1]), .pwm_out_c(pout[2]), .pwm_out_d(pout[3]),
    .pwm_oe_n_a(poe_n[0]), .pwm_oe_n_b(poe_n[1]), .pwm_oe_n_c(poe_n[2]),
    .pwm_oe_n_d(poe_n[3]));

  fault_src_model u_fault_src_model (
    .trip(trip), .pin_out(pout), .pin_oe_n(poe_n), .cmp1_out(cmp1_out),
    .cmp2_out(cmp2_out), .fault_pin_n(fault_pin_n), .pin_level(pin_level));

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // The read notes its expectation; the watcher compares it later.
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic pulse_period();
    @(posedge clk);
    period_start <= 1'b1;
    @(posedge clk);
    period_start <= 1'b0;
  endtask : pulse_period

  // Shut pins follow the drive code; running pins follow raw data and polarity.
  task automatic pins(input logic shut, input logic [7:0] cfg);
    logic [3:0] lv;
    logic [3:0] oe;
    logic [1:0] code;
    #1;
    for (int i = 0; i < 4; i++)
    begin
      code = i[0] ? cfg[1:0] : cfg[3:2];
      oe[i] = shut ? code[1] : (ctl[3:2] != 2'b11);
      lv[i] = shut ? code[0] : pwm_raw[i] ^ (i[0] ? ctl[0] : ctl[1]);
    end
    check("pin_oe_n", {6'h00, poe_n}, {6'h00, oe});
    check("pin_level", {6'h00, pin_level}, {6'h00, lv & ~oe});
  endtask : pins

  // Read data first appear in the cycle after the strobe, so look there.
  always @(posedge clk)
  begin
    if (rd_pend)
      check("reg_rdata", {2'b00, reg_rdata}, {2'b00, exp_q.pop_front()});
    rd_pend = reg_rd;
  end

  // A hang is cut short well past the expected run length.
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial
  begin
    logic [7:0] d, v, cfg;
    void'($urandom(15700));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++)
      rd(i[2:0], 8'h00);
    pins(1'b0, 8'h00);
    d = 8'($urandom);
    v = {1'b1, 7'($urandom)};
    ctl = {4'($urandom), 4'h0};
    wr(reg_duty_low, d);
    wr(reg_pwm_control, ctl);
    wr(reg_deadband_restart, v);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    rd(reg_duty_low, d);
    rd(reg_deadband_restart, v);
    rd(reg_pwm_control, ctl);
    wr(reg_duty_high, ~d);
    rd(reg_duty_high, ~d);
    #1;
    check("duty_value", duty_value, {d, ctl[5:4]});
    check("deadband", {3'h0, deadband_count}, {3'h0, v[6:0]});
    check("config_sel", {8'h00, output_config_sel}, {8'h00, ctl[7:6]});
    for (int p = 3; p >= 0; p--)
    begin
      ctl[3:0] = {2'b00, p[1:0]};
      wr(reg_pwm_control, ctl);
      ctl[3:2] = 2'b11;
      wr(reg_pwm_control, ctl);
      @(posedge clk);
      pwm_raw <= 4'($urandom);
      pins(1'b0, 8'h00);
    end
    // Every source code against every source, with automatic restart.
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 3; k++)
      begin
        cfg = {1'b0, s[2:0], 4'($urandom)};
        wr(reg_shutdown_config, cfg);
        @(posedge clk);
        trip <= 3'(1 << k);
        pwm_raw <= 4'($urandom);
        pins(s[k], cfg);
        repeat (4) @(posedge clk);
        rd(reg_shutdown_config, {s[k], cfg[6:0]});
        trip <= 3'h0;
        repeat (4) @(posedge clk);
        rd(reg_shutdown_config, cfg);
        pins(s[k], cfg);
        pulse_period();
        @(posedge clk);
        pins(1'b0, cfg);
      end
    // Manual restart: a clear is refused while the comparator still trips.
    wr(reg_deadband_restart, {1'b0, v[6:0]});
    cfg = 8'h15;
    wr(reg_shutdown_config, cfg);
    @(posedge clk);
    trip <= 3'h1;
    repeat (4) @(posedge clk);
    wr(reg_shutdown_config, cfg);
    rd(reg_shutdown_config, 8'h95);
    trip <= 3'h0;
    repeat (6) @(posedge clk);
    rd(reg_shutdown_config, 8'h95);
    pulse_period();
    pins(1'b1, cfg);
    wr(reg_shutdown_config, cfg);
    rd(reg_shutdown_config, cfg);
    pins(1'b1, cfg);
    pulse_period();
    @(posedge clk);
    pins(1'b0, cfg);
    // Software forces shutdown with no source; both pairs float.
    wr(reg_shutdown_config, 8'h8A);
    @(posedge clk);
    pins(1'b1, 8'h8A);
    wr(reg_shutdown_config, 8'h0A);
    pulse_period();
    @(posedge clk);
    pins(1'b0, 8'h0A);
    wr(reg_period_status, 8'h00);
    rd(reg_period_status, 8'h00);
    pulse_period();
    rd(reg_period_status, 8'h01);
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule : tb
